// ---- hdl/clpt_timer.v ----
// Purpose: prescaler timer chained into a period timer, AHB-Lite slave
// Assumes: single whole-word transfers; one slave drives hready
// Notes: zero wait states; status clears on read, set wins over clear
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "clpt_regs.vh"
module clpt_timer #(
	parameter CW = 16
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	output reg irq
);
	reg ap_wr_reg;
	reg ap_rd_reg;
	reg [3:0] ap_idx_reg;
	reg pre_start_reg;
	reg per_start_reg;
	reg [1:0] src_reg;
	reg [CW-1:0] pre_reload_reg;
	reg [CW-1:0] per_reload_reg;
	reg [CW-1:0] pre_cnt_reg;
	reg [CW-1:0] per_cnt_reg;
	reg [1:0] stat_reg;
	reg [1:0] mask_reg;
	reg [4:0] div_reg;
	reg tick;
	reg [31:0] rd_next;
	wire ap_valid;
	wire word_ok;
	wire pre_uf;
	wire per_uf;
	wire stat_rd;
	wire [1:0] stat_next;

	// only aligned word accesses decode; others still answer okay
	assign word_ok = (hsize == `CLPT_HSIZE_WORD) && (haddr[1:0] == 2'h0);
	assign ap_valid = hsel && hready && (htrans == `CLPT_HTRANS_NONSEQ);

	// capture the address phase for use in the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_reg <= 1'b0;
			ap_rd_reg <= 1'b0;
			ap_idx_reg <= 4'h0;
		end else begin
			ap_wr_reg <= ap_valid && hwrite && word_ok;
			ap_rd_reg <= ap_valid && !hwrite && word_ok;
			ap_idx_reg <= haddr[5:2];
		end
	end

	// free divider for the div8 and div32 count clocks
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			div_reg <= 5'h00;
		else
			div_reg <= div_reg + 5'h01;
	end

	// count clock enable chosen by source select; 11 is left unused
	always @* begin
		case (src_reg)
		`CLPT_SRC_DIV1: tick = 1'b1;
		`CLPT_SRC_DIV8: tick = (div_reg[2:0] == `CLPT_DIV8_LAST);
		`CLPT_SRC_DIV32: tick = (div_reg == `CLPT_DIV32_LAST);
		default: tick = 1'b0;
		endcase
	end

	// underflow is the tick that finds the counter at zero
	assign pre_uf = pre_start_reg && tick && (pre_cnt_reg == {CW{1'b0}});
	assign per_uf = per_start_reg && pre_uf && (per_cnt_reg == {CW{1'b0}});

	// prescaler in plain timer mode
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pre_cnt_reg <= `CLPT_RELOAD_RST;
		else if (ap_wr_reg && ap_idx_reg == `CLPT_ADDR_PRE_RELOAD &&
				!pre_start_reg)
			pre_cnt_reg <= hwdata[CW-1:0]; // stopped: reload loads count too
		else if (pre_uf)
			pre_cnt_reg <= pre_reload_reg;
		else if (pre_start_reg && tick)
			pre_cnt_reg <= pre_cnt_reg - {{(CW-1){1'b0}}, 1'b1};
	end

	// period timer in event counter mode, fed by prescaler underflows
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			per_cnt_reg <= `CLPT_RELOAD_RST;
		else if (ap_wr_reg && ap_idx_reg == `CLPT_ADDR_PER_RELOAD &&
				!per_start_reg)
			per_cnt_reg <= hwdata[CW-1:0];
		else if (per_uf)
			per_cnt_reg <= per_reload_reg;
		else if (per_start_reg && pre_uf)
			per_cnt_reg <= per_cnt_reg - {{(CW-1){1'b0}}, 1'b1};
	end

	// software registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_start_reg <= 1'b0;
			per_start_reg <= 1'b0;
			src_reg <= `CLPT_SRC_DIV1;
			pre_reload_reg <= `CLPT_RELOAD_RST;
			per_reload_reg <= `CLPT_RELOAD_RST;
			mask_reg <= 2'h0;
		end else if (ap_wr_reg) begin
			case (ap_idx_reg)
			`CLPT_ADDR_CTRL: begin
				pre_start_reg <= hwdata[`CLPT_CTRL_PRE_START];
				per_start_reg <= hwdata[`CLPT_CTRL_PER_START];
				src_reg <= hwdata[`CLPT_CTRL_SRC_HI:`CLPT_CTRL_SRC_LO];
			end
			`CLPT_ADDR_PRE_RELOAD: pre_reload_reg <= hwdata[CW-1:0];
			`CLPT_ADDR_PER_RELOAD: per_reload_reg <= hwdata[CW-1:0];
			`CLPT_ADDR_MASK: mask_reg <= hwdata[1:0];
			default: mask_reg <= mask_reg;
			endcase
		end
	end

	// sticky request bits; a new underflow beats the read clear
	assign stat_rd = ap_rd_reg && (ap_idx_reg == `CLPT_ADDR_STATUS);
	assign stat_next = (stat_rd ? 2'h0 : stat_reg) | {per_uf, pre_uf};
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_reg <= 2'h0;
			irq <= 1'b0;
		end else begin
			stat_reg <= stat_next;
			irq <= |(stat_next & mask_reg);
		end
	end

	// read mux, sampled in the address phase so data meets the data phase
	always @* begin
		rd_next = 32'h0000_0000;
		case (haddr[5:2])
		`CLPT_ADDR_CTRL: begin
			rd_next[`CLPT_CTRL_PRE_START] = pre_start_reg;
			rd_next[`CLPT_CTRL_PER_START] = per_start_reg;
			rd_next[`CLPT_CTRL_SRC_HI:`CLPT_CTRL_SRC_LO] = src_reg;
		end
		`CLPT_ADDR_PRE_RELOAD: rd_next[CW-1:0] = pre_reload_reg;
		`CLPT_ADDR_PER_RELOAD: rd_next[CW-1:0] = per_reload_reg;
		`CLPT_ADDR_PRE_COUNT: rd_next[CW-1:0] = pre_cnt_reg;
		`CLPT_ADDR_PER_COUNT: rd_next[CW-1:0] = per_cnt_reg;
		`CLPT_ADDR_STATUS: rd_next[1:0] = stat_reg;
		`CLPT_ADDR_MASK: rd_next[1:0] = mask_reg;
		default: rd_next = 32'h0000_0000;
		endcase
	end

	// status read returns bits as they stand before the clear
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (ap_valid && !hwrite && word_ok)
				hrdata <= rd_next;
		end
	end
endmodule
`default_nettype wire

// ---- shared/clpt_regs.vh ----
// Purpose: register map and constants of the cascaded long-period timer
// Assumes: AHB-Lite word access, 32-bit data
// Notes: address constants are word indices; byte address is four times
//
// Overview of operation
// - period timer counts prescaler underflows, forming 16-bit counter after 16-bit prescaler
// - prescaler runs as plain timer, period timer as event counter
// - each counter starts only after software sets its start flag
// - prescaler decrements once per count clock tick picked by source select
// - prescaler reloads from its reload register on underflow and keeps counting
// - each prescaler underflow sets the prescaler interrupt request bit
// - period timer decrements once per prescaler underflow, not per clock
// - period timer reloads from its own reload register on underflow
// - each period timer underflow sets the period timer interrupt request bit
// - two-bit source select: 00 undivided, 01 divide by 8, 10 divide by 32
`ifndef CLPT_REGS_VH
`define CLPT_REGS_VH
`define CLPT_ADDR_CTRL 4'h0
`define CLPT_ADDR_PRE_RELOAD 4'h1
`define CLPT_ADDR_PER_RELOAD 4'h2
`define CLPT_ADDR_PRE_COUNT 4'h3
`define CLPT_ADDR_PER_COUNT 4'h4
`define CLPT_ADDR_STATUS 4'h5
`define CLPT_ADDR_MASK 4'h6
`define CLPT_CTRL_PRE_START 0
`define CLPT_CTRL_PER_START 1
`define CLPT_CTRL_SRC_LO 2
`define CLPT_CTRL_SRC_HI 3
`define CLPT_STAT_PRE 0
`define CLPT_STAT_PER 1
`define CLPT_SRC_DIV1 2'h0
`define CLPT_SRC_DIV8 2'h1
`define CLPT_SRC_DIV32 2'h2
`define CLPT_DIV8_LAST 5'h07
`define CLPT_DIV32_LAST 5'h1F
`define CLPT_RELOAD_RST 16'hFFFF
`define CLPT_HTRANS_NONSEQ 2'h2
`define CLPT_HSIZE_WORD 3'h2
`endif

// ---- test/clpt_timer_asserts.sv ----
// Purpose: port checks for the chained timer slave
// Assumes: one clock, hready tied back to hreadyout
// Notes: read data is judged one edge after the address phase
`timescale 1ns/1ps
`default_nettype none
module clpt_timer_chk (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	input wire irq
);
	// a taken word read and the register it names
	wire rd = hsel && hready && htrans == 2'h2 && !hwrite && hsize == 3'h2
		&& haddr[1:0] == 2'h0;
	wire [7:0] a = haddr[7:0];
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	ready_always_a: assert property (hreadyout) else $error("wait state");
	resp_okay_a: assert property (!hresp) else $error("error response");
	hole_zero_a: assert property (rd && a == 8'h1C |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	pre_count_a: assert property (rd && a == 8'h0C |=> !hrdata[31:16])
		else $error("prescaler count too wide");
	per_count_a: assert property (rd && a == 8'h10 |=> !hrdata[31:16])
		else $error("period count too wide");
	reload_wide_a: assert property (rd && a[7:4] == 4'h0 && a[3:2] != 2'h0
		|=> !hrdata[31:16]) else $error("reload too wide");
	src_field_a: assert property (rd && a == 8'h00 |=> !hrdata[31:4])
		else $error("control too wide");
	status_bits_a: assert property (rd && a == 8'h14 |=> !hrdata[31:2])
		else $error("status too wide");
endmodule
bind clpt_timer clpt_timer_chk chk_i (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
	.hresp, .irq);
`default_nettype wire

// ---- test/clpt_timer_bench.sv ----
// Purpose: register-level bench for the chained timer
// Assumes: zero-wait slave, one word per transfer
// Notes: small reloads keep every count short
`timescale 1ns/1ps
`default_nettype none
module clpt_timer_bench;
	logic hclk = 0, hresetn = 0, hwrite = 0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, v;
	wire [31:0] hrdata;
	wire hrdy, hresp, irq;
	int miscompares = 0, cmp_count = 0;
	clpt_timer uut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hrdy), .hrdata, .hreadyout(hrdy),
		.hresp, .irq);
	initial forever #2.5 hclk = ~hclk;
	task chk(input string n, input [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	// address phase held until hready, then data phase held likewise
	task xfer(input w, input [31:0] ad, d);
		haddr <= ad;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (!hrdy) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (!hrdy) @(posedge hclk);
		v = hrdata;
	endtask
	task rd(input [31:0] ad, e);
		xfer(0, ad, 32'h0);
		chk("hrdata", v, e);
	endtask
	task print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// a hang is cut short well past the 130 or so cycles needed
	initial begin
		repeat (5000) @(posedge hclk);
		miscompares++;
		print_verdict;
	end
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		rd(32'h04, 32'hFFFF);
		rd(32'h10, 32'hFFFF);
		rd(32'h1C, 32'h0);
		xfer(1, 32'h04, 32'h3);
		xfer(1, 32'h08, 32'h1);
		xfer(1, 32'h00, 32'h2);
		repeat (20) @(posedge hclk);
		rd(32'h10, 32'h1);
		xfer(1, 32'h00, 32'hF);
		repeat (20) @(posedge hclk);
		rd(32'h0C, 32'h3);
		rd(32'h14, 32'h0);
		$display("test hold done");
		// five undivided ticks from 3: underflow once, land on 2
		xfer(1, 32'h00, 32'h1);
		repeat (3) @(posedge hclk);
		xfer(1, 32'h00, 32'h0);
		rd(32'h0C, 32'h2);
		chk("irq", irq, 1'b0);
		xfer(1, 32'h18, 32'h3);
		repeat (2) @(posedge hclk);
		chk("irq", irq, 1'b1);
		rd(32'h14, 32'h1);
		repeat (2) @(posedge hclk);
		chk("irq", irq, 1'b0);
		$display("test prescaler done");
		// both run; period of reload 1 underflows on every second event
		xfer(1, 32'h00, 32'h3);
		repeat (16) @(posedge hclk);
		xfer(1, 32'h00, 32'h0);
		rd(32'h14, 32'h3);
		rd(32'h14, 32'h0);
		$display("test chain done");
		// 16 MHz source: 16000 ticks per ms, 1000 ms per second
		xfer(1, 32'h04, 32'h0000_3E7F);
		xfer(1, 32'h08, 32'h0000_03E7);
		rd(32'h04, 32'h0000_3E7F);
		rd(32'h08, 32'h0000_03E7);
		rd(32'h0C, 32'h0000_3E7F);
		$display("test reference reloads done");
		print_verdict;
	end
endmodule
`default_nettype wire
